// ### hdl/swd_ctrl.sv
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] watchdog_mode_config,
  input wire swd_pkg::swd_core_t core_in,
  input wire logic [7:0] periph_flags,
  output logic in_sleep_ff,
  output logic wdt_reset_ff,
  output logic fetch_load_ff,
  output logic [12:0] fetch_addr_ff,
  output logic forced_nop_ff
);

  ////////////////////////////////////////////////////////////////////////////
  swd_pkg::swd_ahb_req_t req_ff;
  logic phase_ff;
  logic [7:0] pie_ff;
  logic [7:0] watchdog_control_ff;
  logic gie_ff;
  logic peripheral_irq_gate_ff;
  logic to_ff;
  logic pd_ff;
  swd_pkg::swd_state_t state_ff;
  logic [11:0] lf_div_ff;
  logic [4:0] lf_sub_ff;
  logic [31:0] wdt_cnt_ff;
  logic lf_tick;
  logic ms_tick;
  logic [7:0] eff_en;
  logic wake_pending;
  logic wdt_active;
  logic wdt_clear;
  logic [31:0] wdt_limit;
  logic wdt_expire;
  logic sleep_nop;
  logic sleep_enter;
  logic wake_irq;
  logic wake_wdt;
  logic wr_go;
  logic [31:0] nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign wr_go = phase_ff && req_ff.hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_ff <= '0;
      phase_ff <= 1'b0;
    end
    else if (hready)
    begin
      req_ff <= '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hsel: hsel};
      phase_ff <= hsel && htrans[1];
    end
  end

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[11:0])
      `SWD_ADDR_PIE: nxt_rdata = {24'h00_0000, pie_ff};
      `SWD_ADDR_STATUS: nxt_rdata = {27'h000_0000, to_ff, pd_ff, 3'h0};
      `SWD_ADDR_WDTCTL: nxt_rdata = {24'h00_0000, watchdog_control_ff};
      `SWD_ADDR_IRQCTL: nxt_rdata = {24'h00_0000, gie_ff, peripheral_irq_gate_ff, 6'h00};
      `SWD_ADDR_FLAGS: nxt_rdata = {24'h00_0000, periph_flags};
      `SWD_ADDR_CFG: nxt_rdata = {30'h0000_0000, watchdog_mode_config};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= nxt_rdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pie_ff <= 8'h00;
      watchdog_control_ff <= `SWD_WATCHDOG_CONTROL_RESET;
      gie_ff <= 1'b0;
      peripheral_irq_gate_ff <= 1'b0;
    end
    else if (wr_go)
    begin
      case (req_ff.haddr[11:0])
        `SWD_ADDR_PIE: pie_ff <= hwdata[7:0] & `SWD_PIE_MASK;
        `SWD_ADDR_WDTCTL: watchdog_control_ff <= {2'b00, hwdata[5:0]};
        `SWD_ADDR_IRQCTL:
        begin
          gie_ff <= hwdata[`SWD_BIT_GIE];
          peripheral_irq_gate_ff <= hwdata[`SWD_BIT_PERIPHERAL_IRQ_GATE];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake detection; gate applies to every peripheral source
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_en
      assign eff_en[gi] = pie_ff[gi] && peripheral_irq_gate_ff && periph_flags[gi];
    end
  endgenerate
  assign wake_pending = |eff_en;

  assign sleep_nop = core_in.sleep_exec && state_ff == swd_pkg::SWD_RUN && wake_pending;
  assign sleep_enter = core_in.sleep_exec && state_ff == swd_pkg::SWD_RUN && !wake_pending;
  assign wake_irq = state_ff == swd_pkg::SWD_SLEEP && wake_pending;
  assign wake_wdt = state_ff == swd_pkg::SWD_SLEEP && wdt_expire && !wake_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Time base: 31 kHz divider, 31 source ticks per nominal 1 ms
  assign lf_tick = lf_div_ff == 12'(`SWD_LF_CYCLES - 1);
  assign ms_tick = lf_tick && lf_sub_ff == 5'(`SWD_TICK_LF - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lf_div_ff <= 12'h000;
      lf_sub_ff <= 5'h00;
    end
    else if (wdt_clear)
    begin
      // Prescaler restarts with the count so a fresh period is a full one
      lf_div_ff <= 12'h000;
      lf_sub_ff <= 5'h00;
    end
    else if (lf_tick)
    begin
      lf_div_ff <= 12'h000;
      lf_sub_ff <= (lf_sub_ff == 5'(`SWD_TICK_LF - 1)) ? 5'h00 : lf_sub_ff + 5'h01;
    end
    else
      lf_div_ff <= lf_div_ff + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  always_comb
  begin
    case (watchdog_mode_config)
      `SWD_MODE_ON: wdt_active = 1'b1;
      `SWD_MODE_AWAKE: wdt_active = state_ff != swd_pkg::SWD_SLEEP;
      `SWD_MODE_SW: wdt_active = watchdog_control_ff[`SWD_BIT_SWEN];
      default: wdt_active = 1'b0;
    endcase
  end

  // Period 1 ms << select, select 11 gives 2048 ms
  assign wdt_limit = 32'h0000_0001 << watchdog_control_ff[5:1];
  assign wdt_expire = wdt_active && wdt_cnt_ff >= wdt_limit;
  assign wdt_clear = core_in.wdt_clear || sleep_enter || wake_irq || wake_wdt
    || core_in.osc_fail || !wdt_active;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_cnt_ff <= 32'h0000_0000;
    else if (wdt_clear)
      wdt_cnt_ff <= 32'h0000_0000;
    else if (ms_tick && !wdt_expire)
      wdt_cnt_ff <= wdt_cnt_ff + 32'h0000_0001;
  end

  // Awake time-out resets the device; sleeping time-out only wakes it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_reset_ff <= 1'b0;
    else
      wdt_reset_ff <= wdt_expire && state_ff != swd_pkg::SWD_SLEEP && !wdt_reset_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits: both read 1 after reset; PD low means sleep happened
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
    end
    else if (core_in.wdt_clear)
    begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
    end
    else if (sleep_enter)
    begin
      to_ff <= 1'b1;
      pd_ff <= 1'b0;
    end
    else if (wake_wdt)
      to_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer and fetch control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= swd_pkg::SWD_RUN;
      in_sleep_ff <= 1'b0;
      forced_nop_ff <= 1'b0;
      fetch_load_ff <= 1'b1;
      fetch_addr_ff <= `SWD_RESET_VEC;
    end
    else
    begin
      fetch_load_ff <= 1'b0;
      forced_nop_ff <= 1'b0;
      case (state_ff)
        swd_pkg::SWD_RUN:
          if (sleep_enter)
          begin
            state_ff <= swd_pkg::SWD_SLEEP;
            in_sleep_ff <= 1'b1;
          end
        swd_pkg::SWD_SLEEP:
          if (wake_irq && gie_ff)
          begin
            state_ff <= swd_pkg::SWD_NOP1;
            in_sleep_ff <= 1'b0;
            forced_nop_ff <= 1'b1;
          end
          else if (wake_irq || wake_wdt)
          begin
            state_ff <= swd_pkg::SWD_RUN;
            in_sleep_ff <= 1'b0;
          end
        swd_pkg::SWD_NOP1:
        begin
          state_ff <= swd_pkg::SWD_NOP2;
          forced_nop_ff <= 1'b1;
        end
        swd_pkg::SWD_NOP2:
        begin
          state_ff <= swd_pkg::SWD_RUN;
          fetch_load_ff <= 1'b1;
          fetch_addr_ff <= `SWD_IRQ_VEC;
        end
        default: state_ff <= swd_pkg::SWD_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  no_sleep_nop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_nop |=> state_ff == swd_pkg::SWD_RUN && $stable(pd_ff) && $stable(to_ff))
    else $error("sleep with pending irq changed state");
  sleep_pd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_enter |=> !pd_ff && in_sleep_ff && wdt_cnt_ff == 32'h0)
    else $error("sleep entry did not clear pd");
  wake_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_irq |=> !in_sleep_ff && wdt_cnt_ff == 32'h0)
    else $error("irq wake not immediate");
  gate_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !peripheral_irq_gate_ff |-> !wake_pending)
    else $error("source enabled without gate");
  mode_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_mode_config == `SWD_MODE_ON |-> wdt_active)
    else $error("always-on watchdog inactive");
  mode_awake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_mode_config == `SWD_MODE_AWAKE && in_sleep_ff |-> wdt_cnt_ff == 32'h0)
    else $error("watchdog counting in sleep");
  wdt_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_wdt |=> !to_ff && !in_sleep_ff && !wdt_reset_ff)
    else $error("sleep timeout mishandled");
  vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_irq && gie_ff |=> forced_nop_ff ##1 forced_nop_ff ##1
    fetch_load_ff && fetch_addr_ff == `SWD_IRQ_VEC)
    else $error("vector sequence wrong");
  swen_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_mode_config == `SWD_MODE_SW && !watchdog_control_ff[0] |=> wdt_cnt_ff == 32'h0)
    else $error("software disable ignored");
  prescale_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wdt_clear |=> lf_div_ff == 12'h000 && lf_sub_ff == 5'h00)
    else $error("prescaler not cleared with watchdog");
  pie_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pie_ff & ~`SWD_PIE_MASK) == 8'h00)
    else $error("unimplemented enable bit set");

endmodule // swd_ctrl

// ### hdl/swd_defs.svh
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH

// Register byte addresses on the bus
`define SWD_ADDR_PIE      12'h000
`define SWD_ADDR_STATUS   12'h004
`define SWD_ADDR_WDTCTL   12'h008
`define SWD_ADDR_IRQCTL   12'h00c
`define SWD_ADDR_FLAGS    12'h010
`define SWD_ADDR_CFG      12'h014

// Peripheral enable bit positions
`define SWD_BIT_CONV      6
`define SWD_BIT_OSCOV     4
`define SWD_BIT_LCELL     3
`define SWD_BIT_PERIOD    1
`define SWD_PIE_MASK      8'h5a

// Status and control bit positions
`define SWD_BIT_TO        4
`define SWD_BIT_PD        3
`define SWD_BIT_GIE       7
`define SWD_BIT_PERIPHERAL_IRQ_GATE      6
`define SWD_BIT_SWEN      0

// Watchdog modes
`define SWD_MODE_ON       2'b11
`define SWD_MODE_AWAKE    2'b10
`define SWD_MODE_SW       2'b01

// Time base: 31 kHz source, nominal 1 ms tick
`define SWD_CLK_HZ        100000000
`define SWD_LFOSC_HZ      31000
`define SWD_TICK_NS       1000000
`define SWD_LF_CYCLES     (`SWD_CLK_HZ / `SWD_LFOSC_HZ)
`define SWD_TICK_LF       31
`define SWD_PS_RESET      5'h0b
`define SWD_WATCHDOG_CONTROL_RESET  8'h16

// Vectors
`define SWD_RESET_VEC     13'h0000
`define SWD_IRQ_VEC       13'h0004

`endif

// ### hdl/swd_pkg.sv
package swd_pkg;
  typedef enum logic [1:0] {SWD_RUN, SWD_SLEEP, SWD_NOP1, SWD_NOP2} swd_state_t;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
  } swd_ahb_req_t;
  typedef struct packed {
    logic sleep_exec;
    logic wdt_clear;
    logic osc_fail;
  } swd_core_t;
endpackage

// ### test/sleep_wake_watchdog_control_tb_top.sv
`timescale 1ns/1ps
`include "swd_defs.svh"
module sleep_wake_watchdog_control_tb_top;
  logic hclk, hresetn, hsel, hwrite, sleep_req, clear_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, mode;
  logic [7:0] flag_req, flags;
  logic hreadyout, hresp, in_sleep, wdt_rst, fload, fnop;
  logic [12:0] faddr, vec;
  logic [15:0] lfsr;
  swd_pkg::swd_core_t core;
  int bad_count, num_checks, rst_seen, n, nops;
  swd_ctrl swd_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .watchdog_mode_config(mode),
    .core_in(core), .periph_flags(flags), .in_sleep_ff(in_sleep), .wdt_reset_ff(wdt_rst),
    .fetch_load_ff(fload), .fetch_addr_ff(faddr), .forced_nop_ff(fnop));
  swd_core_model swd_core_model_inst (.hclk(hclk), .hresetn(hresetn), .sleep_req(sleep_req),
    .clear_req(clear_req), .flag_req(flag_req), .core_out(core), .flags_out(flags));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    if (wdt_rst === 1'b1)
      rst_seen++;
  end
  // Sized for one 1 ms expiry plus the short tests
  initial
  begin
    #1500000;
    bad_count++;
    $display("mismatch at %0t: watchdog timeout", $time);
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] exp_status(input logic to, input logic pd);
    return {27'h0, to, pd, 3'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic go_sleep();
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hresetn, hsel, hwrite, sleep_req, clear_req, htrans, mode} = '0;
    {haddr, hwdata, flag_req} = '0;
    lfsr = 16'h5e3f;
    repeat (2) @(posedge hclk);
    chk({19'h0, faddr}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`SWD_ADDR_STATUS, exp_status(1'b1, 1'b1));
    rdchk(`SWD_ADDR_WDTCTL, 32'h16);
    rdchk(12'h020, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      mode <= m[1:0];
      @(posedge hclk);
      rdchk(`SWD_ADDR_CFG, {30'h0, m[1:0]});
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      bus(1'b1, `SWD_ADDR_PIE, {24'h0, lfsr[7:0]});
      rdchk(`SWD_ADDR_PIE, {24'h0, lfsr[7:0] & 8'h5a});
    end
    $display("test enable bits done");
    bus(1'b1, `SWD_ADDR_PIE, 32'h5a);
    flag_req <= 8'h10;
    go_sleep();
    chk(in_sleep, 1'b1);
    bus(1'b1, `SWD_ADDR_IRQCTL, 32'h40);
    repeat (3) @(posedge hclk);
    chk(in_sleep, 1'b0);
    rdchk(`SWD_ADDR_STATUS, exp_status(1'b1, 1'b0));
    $display("test gate and wake done");
    flag_req <= 8'h0a;
    clear_req <= 1'b1;
    @(posedge hclk);
    clear_req <= 1'b0;
    go_sleep();
    chk(in_sleep, 1'b0);
    rdchk(`SWD_ADDR_STATUS, exp_status(1'b1, 1'b1));
    $display("test pending sleep done");
    flag_req <= 8'h00;
    bus(1'b1, `SWD_ADDR_IRQCTL, 32'hc0);
    go_sleep();
    chk(in_sleep, 1'b1);
    flag_req <= 8'h40;
    nops = 0;
    vec = 13'h1fff;
    repeat (10)
    begin
      @(posedge hclk);
      if (fnop === 1'b1)
        nops++;
      if (fload === 1'b1)
        vec = faddr;
    end
    chk(nops, 2);
    chk({19'h0, vec}, 32'h4);
    $display("test vectored wake done");
    flag_req <= 8'h00;
    bus(1'b1, `SWD_ADDR_IRQCTL, 32'h0);
    // Shortest period keeps the expiry near one millisecond
    bus(1'b1, `SWD_ADDR_WDTCTL, 32'h0);
    go_sleep();
    n = 0;
    while (in_sleep === 1'b1 && n < 120000)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n > 95000 && n < 105000), 32'h1);
    chk(rst_seen, 0);
    rdchk(`SWD_ADDR_STATUS, exp_status(1'b0, 1'b0));
    $display("test sleep expiry done");
    tally_and_finish();
  end
endmodule // sleep_wake_watchdog_control_tb_top

// ### test/swd_core_model.sv
`timescale 1ns/1ps
module swd_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sleep_req,
  input wire logic clear_req,
  input wire logic [7:0] flag_req,
  output swd_pkg::swd_core_t core_out,
  output logic [7:0] flags_out
);
  // Instructions retire as one-cycle pulses, flags stay as levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_out <= '0;
      flags_out <= 8'h00;
    end
    else
    begin
      core_out <= '{sleep_exec: sleep_req, wdt_clear: clear_req, osc_fail: 1'b0};
      flags_out <= flag_req;
    end
  end
endmodule // swd_core_model
